// [verilog/smsq_pkg.sv]
// Constants shared by the scan mirror sequencer and its testbench.
// Assumes a single 10 MHz clock domain.
package smsq_pkg;
   // Clock
   localparam int CLK_HZ = 10_000_000;
   // Angular step sizes, microradians
   localparam int EW_INC_MECH_URAD = 8;
   localparam int EW_INC_OPT_URAD = 16;
   localparam int NS_INC_URAD = 8;
   // Rates
   localparam int SLEW_RATE_DEG_S = 10;
   localparam int SCAN_RATE_OPT_DEG_S = 20;
   localparam int IR_RATE_HZ = 5460;
   localparam int VIS_RATE_HZ = 21840;
   // Sample footprints, microradians east-west
   localparam int VIS_SAMPLE_URAD = 16;
   localparam int IR_SAMPLE_URAD = 64;
   localparam int VIS_PER_BLOCK = IR_SAMPLE_URAD / VIS_SAMPLE_URAD;
   // One step per visible sample; longest period rounds down
   localparam int STEP_DIV_CYC = CLK_HZ / VIS_RATE_HZ;
   // Line reversal
   localparam int REV_TIME_MS = 200;
   localparam int REV_CYC = CLK_HZ / 1000 * REV_TIME_MS;
   localparam int REV_STEPS = 32;
   localparam logic [4:0] REV_LAST = 5'h1F;
   localparam logic [4:0] NS_REV_INCS = 5'h1C;
   localparam int NS_REV_URAD = 224;
   // Quarter-wave cosine magnitude, steps per reversal sub-interval
   localparam logic [7:0] COS_TAB [16] = '{8'h88, 8'h87, 8'h84, 8'h80, 8'h7B, 8'h75, 8'h6D, 8'h65,
                                           8'h5B, 8'h51, 8'h46, 8'h3A, 8'h2E, 8'h21, 8'h14, 8'h07};
   // Subprogram dwell, 0.2 s
   localparam int DWELL_TIME_MS = 200;
   localparam int DWELL_CYC = CLK_HZ / 1000 * DWELL_TIME_MS;
   localparam int CLAMP_LINES = 4;
   // Detectors
   localparam int N_VIS = 8;
   localparam int N_IR_SIDE = 7;
   localparam int N_DET = 22;
   // Command kinds
   localparam logic [1:0] KIND_FRAME = 2'h0;
   localparam logic [1:0] KIND_PRIO = 2'h1;
   localparam logic [1:0] KIND_STAR = 2'h2;
   // What follows a completed slew
   localparam logic [1:0] RET_SCAN = 2'h0;
   localparam logic [1:0] RET_HOLD = 2'h1;
   localparam logic [1:0] RET_DWELL = 2'h2;
   localparam logic [1:0] RET_RESUME = 2'h3;
endpackage

// [verilog/smsq_corr_mem.sv]
// Fixed-pattern pointing correction store, one word per scan address.
// Assumes the loader writes it before scanning; read data is registered.
module smsq_corr_mem #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 6
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem [2**ADDR_W];

   if (ADDR_W < 1 || ADDR_W > 12)
   begin : g_chk
      $error("smsq_corr_mem: ADDR_W out of range");
   end

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // smsq_corr_mem

// [verilog/smsq_top.sv]
// Scan mirror sequencer: slews, bidirectional lines, cosine reversals, sampling.
// Assumes commands come from controller logic on the same clock.
module smsq_top #(
   parameter int POS_W = 16,
   parameter int INC_BITS = 8,
   parameter int CORR_W = 6,
   parameter int STEP_DIV = smsq_pkg::STEP_DIV_CYC,
   parameter int REV_CYC = smsq_pkg::REV_CYC,
   parameter int DWELL_CYC = smsq_pkg::DWELL_CYC,
   parameter int CLAMP_LINES = smsq_pkg::CLAMP_LINES,
   parameter logic [15:0] SPACE_EW = 16'h0000,
   parameter logic [15:0] SPACE_NS = 16'h0000,
   parameter logic [15:0] BB_EW = 16'h0000,
   parameter logic [15:0] BB_NS = 16'h0000
) (
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic CMD_VALID,
   input wire logic [1:0] CMD_KIND,
   input wire logic [POS_W-1:0] CMD_START_EW,
   input wire logic [POS_W-1:0] CMD_START_NS,
   input wire logic [POS_W-1:0] CMD_END_EW,
   input wire logic [POS_W-1:0] CMD_END_NS,
   input wire logic CAL_REQ,
   input wire logic SIDE_SEL,
   input wire logic CORR_WE,
   input wire logic [INC_BITS-1:0] CORR_ADDR,
   input wire logic [CORR_W-1:0] CORR_DATA,
   output logic EW_STEP,
   output logic EW_DIR,
   output logic NS_STEP,
   output logic NS_DIR,
   output logic [POS_W-INC_BITS-1:0] EW_CYCLE,
   output logic [INC_BITS-1:0] EW_INCR,
   output logic [POS_W-INC_BITS-1:0] NS_CYCLE,
   output logic [INC_BITS-1:0] NS_INCR,
   output logic START_OF_LINE,
   output logic VIS_SAMPLE,
   output logic IR_SAMPLE,
   output logic [smsq_pkg::N_VIS-1:0] VIS_EN,
   output logic [smsq_pkg::N_IR_SIDE-1:0] UPPER_IR_EN,
   output logic [smsq_pkg::N_IR_SIDE-1:0] LOWER_IR_EN,
   output logic BUSY,
   output logic SPACE_LOOK,
   output logic BB_LOOK
);
   typedef enum logic [2:0] {S_IDLE, S_SLEW_EW, S_SLEW_NS, S_SOL, S_SCAN, S_REV, S_DWELL, S_HOLD} smsq_state_e;

   typedef struct packed {
      smsq_state_e state;
      logic [1:0] ret;
      logic [POS_W-1:0] ew_pos;
      logic [POS_W-1:0] ns_pos;
      logic [POS_W-1:0] tgt_ew;
      logic [POS_W-1:0] tgt_ns;
      logic [POS_W-1:0] sav_ew;
      logic [POS_W-1:0] sav_ns;
      logic [POS_W-1:0] start_ew;
      logic [POS_W-1:0] end_ew;
      logic [POS_W-1:0] end_ns;
      logic [POS_W-1:0] cmd_ew;
      logic [POS_W-1:0] cmd_ns;
      logic line_west;
      logic star;
      logic cal_pend;
      logic [15:0] div_cnt;
      logic [4:0] sub_cnt;
      logic [23:0] sub_tim;
      logic [23:0] acc;
      logic [1:0] smp_cnt;
      logic [7:0] line_cnt;
      logic [23:0] dwell;
      logic ew_step;
      logic ew_dir;
      logic ns_step;
      logic ns_dir;
      logic sol;
      logic vis_smp;
      logic ir_smp;
      logic space_look;
      logic bb_look;
      logic busy;
      logic [smsq_pkg::N_VIS-1:0] vis_en;
      logic [smsq_pkg::N_IR_SIDE-1:0] up_en;
      logic [smsq_pkg::N_IR_SIDE-1:0] lo_en;
   } smsq_state_s;

   localparam logic [23:0] SUB_CYC = 24'(REV_CYC / smsq_pkg::REV_STEPS);
   localparam logic [23:0] DWELL_LAST = 24'(DWELL_CYC - 1);
   localparam logic [15:0] DIV_LAST = 16'(STEP_DIV - 1);
   localparam logic [7:0] CLAMP_N = 8'(CLAMP_LINES);

   if (STEP_DIV < 16 || STEP_DIV > 65535 || REV_CYC / smsq_pkg::REV_STEPS <= 136 ||
       REV_CYC >= 2**28 || DWELL_CYC < 1 || DWELL_CYC >= 2**24 || CLAMP_LINES < 1 ||
       CLAMP_LINES > 255 || POS_W != 16 || INC_BITS < 1 || INC_BITS >= POS_W || CORR_W >= POS_W)
   begin : g_chk
      $error("smsq_top: parameter out of range");
   end

   smsq_state_s st_reg;
   smsq_state_s st_next;
   logic [CORR_W-1:0] corr;
   logic tick;
   logic [7:0] mag;
   logic [23:0] sum;
   logic line_end;

   // Correction table addressed by the increment within the encoder cycle
   smsq_corr_mem #(
      .ADDR_W(INC_BITS),
      .DATA_W(CORR_W)
   ) u_corr (
      .clk(CLOCK),
      .wr_en(CORR_WE),
      .wr_addr(CORR_ADDR),
      .wr_data(CORR_DATA),
      .rd_addr(st_reg.ew_pos[INC_BITS-1:0]),
      .rd_data(corr)
   );

   function automatic logic [POS_W-1:0] bump(input logic [POS_W-1:0] p, input logic down);
      return down ? p - 1'b1 : p + 1'b1;
   endfunction

   always_comb
   begin
      st_next = st_reg;
      tick = st_reg.div_cnt == DIV_LAST;
      mag = smsq_pkg::COS_TAB[st_reg.sub_cnt[4] ? ~st_reg.sub_cnt[3:0] : st_reg.sub_cnt[3:0]];
      sum = st_reg.acc + {16'h0000, mag};
      line_end = st_reg.ew_pos == (st_reg.line_west ? st_reg.end_ew : st_reg.start_ew);
      st_next.ew_step = 1'b0;
      st_next.ns_step = 1'b0;
      st_next.sol = 1'b0;
      st_next.vis_smp = 1'b0;
      st_next.ir_smp = 1'b0;
      // Free-running divider keeps every slew and scan step period identical
      st_next.div_cnt = tick ? 16'h0000 : st_reg.div_cnt + 16'h0001;
      st_next.vis_en = '1;
      st_next.up_en = SIDE_SEL ? '0 : '1;
      st_next.lo_en = SIDE_SEL ? '1 : '0;
      // Correction lags position by one cycle through the registered table
      if (st_reg.star)
      begin
         st_next.cmd_ew = st_reg.ew_pos;
      end
      else
      begin
         st_next.cmd_ew = st_reg.ew_pos + {{(POS_W-CORR_W){corr[CORR_W-1]}}, corr};
      end
      st_next.cmd_ns = st_reg.ns_pos;
      if (CMD_VALID && (st_reg.state == S_IDLE || st_reg.state == S_HOLD || CMD_KIND == smsq_pkg::KIND_PRIO))
      begin
         // A priority frame preempts anything in progress
         st_next.start_ew = CMD_START_EW;
         st_next.end_ew = CMD_END_EW;
         st_next.end_ns = CMD_END_NS;
         st_next.tgt_ew = CMD_START_EW;
         st_next.tgt_ns = CMD_START_NS;
         st_next.star = CMD_KIND == smsq_pkg::KIND_STAR;
         st_next.ret = CMD_KIND == smsq_pkg::KIND_STAR ? smsq_pkg::RET_HOLD : smsq_pkg::RET_SCAN;
         st_next.line_west = 1'b1;
         st_next.line_cnt = 8'h00;
         st_next.space_look = 1'b0;
         st_next.bb_look = 1'b0;
         st_next.state = S_SLEW_EW;
      end
      else
      begin
         case (st_reg.state)
            S_SLEW_EW:
            begin
               if (st_reg.ew_pos == st_reg.tgt_ew)
               begin
                  st_next.state = S_SLEW_NS;
               end
               else if (tick)
               begin
                  st_next.ew_step = 1'b1;
                  st_next.ew_dir = st_reg.tgt_ew < st_reg.ew_pos;
                  st_next.ew_pos = bump(st_reg.ew_pos, st_reg.tgt_ew < st_reg.ew_pos);
               end
            end
            S_SLEW_NS:
            begin
               if (st_reg.ns_pos == st_reg.tgt_ns)
               begin
                  case (st_reg.ret)
                     smsq_pkg::RET_HOLD: st_next.state = S_HOLD;
                     smsq_pkg::RET_DWELL:
                     begin
                        st_next.dwell = 24'h000000;
                        st_next.state = S_DWELL;
                     end
                     default: st_next.state = S_SOL;
                  endcase
               end
               else if (tick)
               begin
                  // Origin at the northwest corner: south counts up
                  st_next.ns_step = 1'b1;
                  st_next.ns_dir = st_reg.tgt_ns < st_reg.ns_pos;
                  st_next.ns_pos = bump(st_reg.ns_pos, st_reg.tgt_ns < st_reg.ns_pos);
               end
            end
            S_SOL:
            begin
               st_next.sol = 1'b1;
               st_next.smp_cnt = 2'h0;
               st_next.state = S_SCAN;
            end
            S_SCAN:
            begin
               if (line_end)
               begin
                  st_next.sub_cnt = 5'h00;
                  st_next.sub_tim = 24'h000000;
                  st_next.acc = 24'h000000;
                  // Stop rather than overshoot the southern limit
                  if (st_reg.ns_pos + POS_W'(smsq_pkg::NS_REV_INCS) > st_reg.end_ns)
                  begin
                     st_next.state = S_IDLE;
                  end
                  else
                  begin
                     st_next.state = S_REV;
                  end
               end
               else if (tick)
               begin
                  st_next.ew_step = 1'b1;
                  st_next.ew_dir = st_reg.line_west;
                  st_next.ew_pos = bump(st_reg.ew_pos, st_reg.line_west);
                  st_next.vis_smp = 1'b1;
                  st_next.ir_smp = st_reg.smp_cnt == 2'h0;
                  st_next.smp_cnt = st_reg.smp_cnt + 2'h1;
               end
            end
            S_REV:
            begin
               // Rate-accumulator spreads each sub-interval's steps evenly
               if (sum >= SUB_CYC)
               begin
                  st_next.acc = sum - SUB_CYC;
                  st_next.ew_step = 1'b1;
                  st_next.ew_dir = st_reg.line_west ^ st_reg.sub_cnt[4];
                  st_next.ew_pos = bump(st_reg.ew_pos, st_reg.line_west ^ st_reg.sub_cnt[4]);
               end
               else
               begin
                  st_next.acc = sum;
               end
               if (st_reg.sub_tim == 24'h000000 && st_reg.sub_cnt < smsq_pkg::NS_REV_INCS)
               begin
                  st_next.ns_step = 1'b1;
                  st_next.ns_dir = 1'b0;
                  st_next.ns_pos = st_reg.ns_pos + 1'b1;
               end
               if (st_reg.sub_tim == SUB_CYC - 24'h000001)
               begin
                  st_next.sub_tim = 24'h000000;
                  st_next.sub_cnt = st_reg.sub_cnt + 5'h01;
                  if (st_reg.sub_cnt == smsq_pkg::REV_LAST)
                  begin
                     st_next.line_west = ~st_reg.line_west;
                     st_next.line_cnt = st_reg.line_cnt + 8'h01;
                     // Subprograms run only at a line turn, so no line is cut
                     if (st_reg.cal_pend || st_reg.line_cnt + 8'h01 >= CLAMP_N)
                     begin
                        st_next.sav_ew = st_next.ew_pos;
                        st_next.sav_ns = st_next.ns_pos;
                        st_next.bb_look = st_reg.cal_pend;
                        st_next.space_look = ~st_reg.cal_pend;
                        st_next.tgt_ew = st_reg.cal_pend ? BB_EW : SPACE_EW;
                        st_next.tgt_ns = st_reg.cal_pend ? BB_NS : SPACE_NS;
                        st_next.cal_pend = 1'b0;
                        st_next.line_cnt = st_reg.cal_pend ? st_reg.line_cnt + 8'h01 : 8'h00;
                        st_next.ret = smsq_pkg::RET_DWELL;
                        st_next.state = S_SLEW_EW;
                     end
                     else
                     begin
                        st_next.state = S_SOL;
                     end
                  end
               end
               else
               begin
                  st_next.sub_tim = st_reg.sub_tim + 24'h000001;
               end
            end
            S_DWELL:
            begin
               st_next.dwell = st_reg.dwell + 24'h000001;
               if (st_reg.dwell == DWELL_LAST)
               begin
                  st_next.tgt_ew = st_reg.sav_ew;
                  st_next.tgt_ns = st_reg.sav_ns;
                  st_next.space_look = 1'b0;
                  st_next.bb_look = 1'b0;
                  st_next.ret = smsq_pkg::RET_RESUME;
                  st_next.state = S_SLEW_EW;
               end
            end
            default:
            begin
               st_next.state = st_reg.state;
            end
         endcase
      end
      st_next.busy = st_next.state != S_IDLE && st_next.state != S_HOLD;
      // Request arriving with the clear is kept
      if (CAL_REQ)
      begin
         st_next.cal_pend = 1'b1;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         st_reg <= '0;
         st_reg.vis_en <= '1;
         st_reg.up_en <= '1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign EW_STEP = st_reg.ew_step;
   assign EW_DIR = st_reg.ew_dir;
   assign NS_STEP = st_reg.ns_step;
   assign NS_DIR = st_reg.ns_dir;
   assign EW_CYCLE = st_reg.cmd_ew[POS_W-1:INC_BITS];
   assign EW_INCR = st_reg.cmd_ew[INC_BITS-1:0];
   assign NS_CYCLE = st_reg.cmd_ns[POS_W-1:INC_BITS];
   assign NS_INCR = st_reg.cmd_ns[INC_BITS-1:0];
   assign START_OF_LINE = st_reg.sol;
   assign VIS_SAMPLE = st_reg.vis_smp;
   assign IR_SAMPLE = st_reg.ir_smp;
   assign VIS_EN = st_reg.vis_en;
   assign UPPER_IR_EN = st_reg.up_en;
   assign LOWER_IR_EN = st_reg.lo_en;
   assign BUSY = st_reg.busy;
   assign SPACE_LOOK = st_reg.space_look;
   assign BB_LOOK = st_reg.bb_look;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);

   property p_idle_wait;
      (st_reg.state == S_IDLE && !CMD_VALID) |=> st_reg.state == S_IDLE;
   endproperty
   a_idle_wait: assert property (p_idle_wait) else $error("scan started without command");

   property p_ew_first;
      st_reg.state == S_SLEW_NS |-> st_reg.ew_pos == st_reg.tgt_ew;
   endproperty
   a_ew_first: assert property (p_ew_first) else $error("north-south slew before east-west done");

   property p_step_space;
      (st_reg.ew_step && st_reg.state == S_SCAN && !line_end) |=> !st_reg.ew_step [*8];
   endproperty
   a_step_space: assert property (p_step_space) else $error("scan steps too close");

   property p_ns28;
      (st_reg.ns_step && $past(st_reg.state) == S_REV) |-> $past(st_reg.sub_cnt) < 5'h1C;
   endproperty
   a_ns28: assert property (p_ns28) else $error("reversal south step beyond 28");

   property p_dir_flip;
      (st_reg.state != S_REV && $past(st_reg.state) == S_REV) |-> st_reg.line_west != $past(st_reg.line_west);
   endproperty
   a_dir_flip: assert property (p_dir_flip) else $error("line direction not reversed");

   property p_ir_block;
      IR_SAMPLE |-> VIS_SAMPLE && $past(st_reg.smp_cnt) == 2'h0;
   endproperty
   a_ir_block: assert property (p_ir_block) else $error("infrared sample off block boundary");

   property p_side;
      (&VIS_EN) && ((UPPER_IR_EN ^ LOWER_IR_EN) == 7'h7F);
   endproperty
   a_side: assert property (p_side) else $error("detector enables wrong");

   property p_star_raw;
      (st_reg.state == S_HOLD && st_reg.star) [*2] |-> st_reg.cmd_ew == st_reg.ew_pos;
   endproperty
   a_star_raw: assert property (p_star_raw) else $error("correction applied while star sensing");

   property p_sol;
      START_OF_LINE |=> !START_OF_LINE && st_reg.state == S_SCAN;
   endproperty
   a_sol: assert property (p_sol) else $error("start of line not followed by scan");
endmodule // smsq_top

// [test/smsq_ctrl_model.sv]
// Controller model: issues frame, star and priority commands to the sequencer.
// Assumes the bench calls send_cmd from one thread, one command at a time.
module smsq_ctrl_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [1:0] cmd_kind,
   output logic [15:0] start_ew,
   output logic [15:0] start_ns,
   output logic [15:0] end_ew,
   output logic [15:0] end_ns
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cmd_valid = 1'b0;
      cmd_kind = 2'h0;
      start_ew = 16'h0000;
      start_ns = 16'h0000;
      end_ew = 16'h0000;
      end_ns = 16'h0000;
   end

   // One strobe carries start and end together; fields are scrambled once released
   task automatic send_cmd(input logic [1:0] kind, input logic [15:0] s_ew, input logic [15:0] s_ns,
                           input logic [15:0] e_ew, input logic [15:0] e_ns);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_kind <= kind;
      start_ew <= s_ew;
      start_ns <= s_ns;
      end_ew <= e_ew;
      end_ns <= e_ns;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_kind <= ~kind;
      start_ew <= ~s_ew;
      start_ns <= ~s_ns;
      end_ew <= ~e_ew;
      end_ns <= ~e_ns;
   endtask
endmodule // smsq_ctrl_model

// [test/smsq_top_tb.sv]
// Bench for the scan mirror sequencer with shortened step, reversal and dwell counts.
// Assumes the controller model drives the command port; correction table loaded here.
module smsq_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 16;
   localparam int REV = 8192;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic side_sel = 1'b0;
   logic corr_we = 1'b0;
   logic cal_req = 1'b0;
   logic [7:0] corr_addr = 8'h00;
   logic [5:0] corr_data = 6'h00;
   logic cmd_valid, ew_step, ew_dir, ns_step, ns_dir, sol, vis, ir, busy, bb, sp;
   logic [1:0] cmd_kind;
   logic [15:0] s_ew, s_ns, e_ew, e_ns;
   logic [7:0] ew_cyc, ew_inc, ns_cyc, ns_inc, vis_en;
   logic [6:0] up_en, lo_en;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   int ew_n, ns_n, vis_n, ir_n, sol_n, ew_pos, gap, last_gap, first_ns_ew, bb_ns, sp_ns;
   int snap[6];

   smsq_ctrl_model smsq_ctrl_model_i (.clk(clock), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .start_ew(s_ew), .start_ns(s_ns), .end_ew(e_ew), .end_ns(e_ns));

   smsq_top #(.STEP_DIV(DIV), .REV_CYC(REV), .DWELL_CYC(50), .CLAMP_LINES(2)) smsq_top_i (.CLOCK(clock),
      .SRST(srst), .CMD_VALID(cmd_valid), .CMD_KIND(cmd_kind), .CMD_START_EW(s_ew), .CMD_START_NS(s_ns),
      .CMD_END_EW(e_ew), .CMD_END_NS(e_ns), .CAL_REQ(cal_req), .SIDE_SEL(side_sel), .CORR_WE(corr_we),
      .CORR_ADDR(corr_addr), .CORR_DATA(corr_data), .EW_STEP(ew_step), .EW_DIR(ew_dir), .NS_STEP(ns_step),
      .NS_DIR(ns_dir), .EW_CYCLE(ew_cyc), .EW_INCR(ew_inc), .NS_CYCLE(ns_cyc), .NS_INCR(ns_inc),
      .START_OF_LINE(sol), .VIS_SAMPLE(vis), .IR_SAMPLE(ir), .VIS_EN(vis_en), .UPPER_IR_EN(up_en),
      .LOWER_IR_EN(lo_en), .BUSY(busy), .SPACE_LOOK(sp), .BB_LOOK(bb));

   always #50 clock = ~clock;

   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // Event counters; snapshots pin the phase boundaries of the first line
   always @(posedge clock)
   begin
      cycles++;
      gap++;
      if (ew_step === 1'b1)
      begin
         ew_n++;
         ew_pos += (ew_dir === 1'b1) ? -1 : 1;
         last_gap = gap;
         gap = 0;
      end
      if (ns_step === 1'b1)
      begin
         if (ns_n == 0)
            first_ns_ew = ew_n;
         if (ns_n == 4 && sol_n == 1)
         begin
            snap[0] = vis_n;
            snap[1] = ir_n;
            snap[2] = ew_pos;
            snap[3] = last_gap;
         end
         if (bb === 1'b1)
            bb_ns++;
         if (sp === 1'b1)
            sp_ns++;
         ns_n++;
      end
      if (vis === 1'b1)
         vis_n++;
      if (ir === 1'b1)
         ir_n++;
      if (sol === 1'b1)
      begin
         if (sol_n == 1)
         begin
            snap[4] = ns_n;
            snap[5] = ew_pos;
         end
         sol_n++;
      end
      // Two reversals dominate the longest scenario
      if (cycles == 50000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic clear_counts;
      @(negedge clock);
      {ew_n, ns_n, vis_n, ir_n, sol_n, ew_pos, first_ns_ew, bb_ns, sp_ns} = '0;
   endtask

   task automatic wait_idle;
      repeat (3) @(negedge clock);
      for (int i = 0; i < 30000 && busy !== 1'b0; i++)
         @(negedge clock);
      repeat (3) @(negedge clock);
      chk("idle", 0, busy);
   endtask

   task automatic t_reset_side;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      clear_counts();
      chk("busy", 0, busy);
      chk("ns_pos", 16'h0000, {ns_cyc, ns_inc});
      chk("vis_en", 8'hFF, vis_en);
      chk("upper_en", 7'h7F, up_en);
      chk("lower_en", 7'h00, lo_en);
      @(posedge clock);
      side_sel <= 1'b1;
      repeat (3) @(negedge clock);
      chk("upper_en", 7'h00, up_en);
      chk("lower_en", 7'h7F, lo_en);
      chk("vis_en", 8'hFF, vis_en);
   endtask

   // Table zeroed except one entry of minus one at east-west increment 0x10
   task automatic t_load_corr;
      for (int a = 0; a < 256; a++)
      begin
         @(posedge clock);
         corr_we <= 1'b1;
         corr_addr <= 8'(a);
         corr_data <= (a == 16) ? 6'h3F : 6'h00;
      end
      @(posedge clock);
      corr_we <= 1'b0;
      repeat (20) @(negedge clock);
      chk("idle_steps", 0, ew_n + ns_n);
   endtask

   task automatic t_frame;
      int exp_rev;
      exp_rev = 0;
      for (int k = 0; k < 16; k++)
         exp_rev += 2 * int'(smsq_pkg::COS_TAB[k]);
      clear_counts();
      smsq_ctrl_model_i.send_cmd(smsq_pkg::KIND_FRAME, 16'h0010, 16'h0004, 16'h0008, 16'h0020);
      wait_idle();
      chk("ew_before_ns", 16, first_ns_ew);
      chk("vis_line1", 8, snap[0]);
      chk("ir_line1", 2, snap[1]);
      chk("ew_line_end", 8, snap[2]);
      chk("step_gap", DIV, snap[3]);
      chk("ns_after_rev", 32, snap[4]);
      chk("ew_after_rev", 8, snap[5]);
      chk("sol_count", 2, sol_n);
      chk("ew_steps", 32 + exp_rev, ew_n);
      chk("ns_pos", 16'h0020, {ns_cyc, ns_inc});
      chk("ew_corr", 16'h000F, {ew_cyc, ew_inc});
   endtask

   task automatic t_star;
      clear_counts();
      smsq_ctrl_model_i.send_cmd(smsq_pkg::KIND_STAR, 16'h0010, 16'h0010, 16'h0000, 16'h0000);
      wait_idle();
      chk("star_ns_steps", 16, ns_n);
      chk("star_ns_dir", 1, ns_dir);
      chk("star_ns", 16'h0010, {ns_cyc, ns_inc});
      chk("star_ew", 16'h0010, {ew_cyc, ew_inc});
   endtask

   // Calibration pending at the first turn; the second turn is due a space look
   task automatic t_cal;
      clear_counts();
      @(posedge clock);
      cal_req <= 1'b1;
      @(posedge clock);
      cal_req <= 1'b0;
      smsq_ctrl_model_i.send_cmd(smsq_pkg::KIND_FRAME, 16'h0010, 16'h0004, 16'h0008, 16'h003C);
      wait_idle();
      chk("cal_bb_ns", 32, bb_ns);
      chk("cal_space_ns", 60, sp_ns);
      chk("cal_ns_steps", 252, ns_n);
      chk("cal_sol", 3, sol_n);
      chk("cal_ns", 16'h003C, {ns_cyc, ns_inc});
      chk("cal_ew", 16'h0008, {ew_cyc, ew_inc});
      chk("cal_looks", 0, {bb, sp});
   endtask

   initial
   begin
      t_reset_side();
      t_load_corr();
      t_frame();
      t_star();
      t_cal();
      tally_and_finish();
   end
endmodule // smsq_top_tb
